/* File: core/svs_filter.sv */
`timescale 1ns/1ps
// ==========================================
// one monitored channel: deglitch and short-to-ground timing
module svs_filter #(
    parameter int DEG     = 800,
    parameter int STG     = 300000,
    parameter bit HAS_DUV = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // comparator levels
    input  wire logic en,
    input  wire logic ov,
    input  wire logic uv,
    input  wire logic duv,
    // filtered events
    output logic      ov_evt,
    output logic      uv_evt,
    output logic      stg_evt
);
    localparam int DW = $clog2(DEG + 1);
    localparam int SW = $clog2(STG + 1);
    localparam logic [DW-1:0] DEG_V = DW'(DEG);
    localparam logic [SW-1:0] STG_V = SW'(STG);

    logic [DW-1:0] ov_cnt_q;
    logic [DW-1:0] uv_cnt_q;
    logic [DW-1:0] duv_cnt_q;
    logic [SW-1:0] stg_cnt_q;

    // ==========================================
    // counters restart when the level returns or supervision is off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ov_cnt_q <= '0;
        end else if (!en || !ov) begin
            ov_cnt_q <= '0;
        end else if (ov_cnt_q != DEG_V) begin
            ov_cnt_q <= ov_cnt_q + DW'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            uv_cnt_q <= '0;
        end else if (!en || !uv) begin
            uv_cnt_q <= '0;
        end else if (uv_cnt_q != DEG_V) begin
            uv_cnt_q <= uv_cnt_q + DW'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            duv_cnt_q <= '0;
        end else if (!HAS_DUV || !en || !duv) begin
            duv_cnt_q <= '0;
        end else if (duv_cnt_q != DEG_V) begin
            duv_cnt_q <= duv_cnt_q + DW'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stg_cnt_q <= '0;
        end else if (!en || !uv) begin
            stg_cnt_q <= '0;
        end else if (stg_cnt_q != STG_V) begin
            stg_cnt_q <= stg_cnt_q + SW'(1);
        end
    end

    assign ov_evt  = (ov_cnt_q == DEG_V);
    assign uv_evt  = (uv_cnt_q == DEG_V);
    assign stg_evt = (stg_cnt_q == STG_V) || (HAS_DUV && duv_cnt_q == DEG_V);

    // ==========================================
    // checks
    a_ov_restart: assert property (@(posedge clk) disable iff (!nrst) !ov |=> !ov_evt)
        else $error("overvoltage event survived a return inside limits");
    a_disabled_quiet: assert property (@(posedge clk) disable iff (!nrst)
        !en |=> !ov_evt && !uv_evt && !stg_evt)
        else $error("event raised on an unsupervised channel");
    a_uv_glitch: assert property (@(posedge clk) disable iff (!nrst)
        $rose(uv) |-> !uv_evt [*2])
        else $error("undervoltage event raised without deglitch delay");
endmodule

/* File: core/svs_sync.sv */
`timescale 1ns/1ps
// ==========================================
// three-stage synchroniser, output moves when stages two and three agree
module svs_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] stable_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;

    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stable_q <= '0;
        end else begin
            stable_q <= (agree & s3_q) | (~agree & stable_q);
        end
    end
endmodule

/* File: core/svs_top.sv */
`timescale 1ns/1ps
module svs_top #(
    parameter int IFACE_STG = svs_pkg::IFACE_STG_CYC,
    parameter int RAIL_STG  = svs_pkg::RAIL_STG_CYC,
    parameter int DEG       = svs_pkg::DEG_CYC
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     nrst,
    // comparator results, asynchronous
    input  wire logic                     iface_ov_in,
    input  wire logic                     iface_uv_in,
    input  wire logic [2:0]               rail_ov_in,
    input  wire logic [2:0]               rail_uv_in,
    input  wire logic [1:0]               rail_duv_in,
    input  wire logic [1:0]               ext_ov_in,
    input  wire logic [1:0]               ext_uv_in,
    input  wire logic                     battery_low_in,
    input  wire logic [1:0]               ref_warn_in,
    input  wire logic [1:0]               ref_err_in,
    // rail enables from the sequencer
    input  wire logic [2:0]               rail_on_in,
    input  wire logic [1:0]               ext_on_req,
    // register port
    input  wire logic [svs_pkg::AW-1:0]   addr,
    input  wire logic [31:0]              wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [31:0]              rdata_q,
    // reset output pin
    output logic                          reset_output_o,
    output logic                          reset_output_oe_n,
    // system controls
    output logic                          hard_reset_q,
    output logic                          failsafe_q,
    output logic [1:0]                    ext_enable_q,
    output logic                          irq_q
);
    // ==========================================
    // input synchronisers
    localparam int NS = 2 * svs_pkg::NCH + 2 + 1 + 2 + 2;

    logic [NS-1:0]           raw;
    logic [NS-1:0]           syn;
    logic [svs_pkg::NCH-1:0] ov_s;
    logic [svs_pkg::NCH-1:0] uv_s;
    logic [svs_pkg::NCH-1:0] duv_s;
    logic                    batt_s;
    logic [1:0]              warn_s;
    logic [1:0]              err_s;

    assign raw = {ref_err_in, ref_warn_in, battery_low_in, rail_duv_in,
                  ext_uv_in, rail_uv_in, iface_uv_in,
                  ext_ov_in, rail_ov_in, iface_ov_in};

    svs_sync #(
        .W (NS)
    ) u_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in (raw),
        .stable_q (syn)
    );

    assign ov_s   = syn[5:0];
    assign uv_s   = syn[11:6];
    assign duv_s  = {4'h0, syn[13:12]} << 1;
    assign batt_s = syn[14];
    assign warn_s = syn[16:15];
    assign err_s  = syn[18:17];

    // ==========================================
    // channel supervision
    logic [svs_pkg::NCH-1:0] ch_en;
    logic [svs_pkg::NCH-1:0] ov_e;
    logic [svs_pkg::NCH-1:0] uv_e;
    logic [svs_pkg::NCH-1:0] stg_e;

    // interface always supervised; rails follow the sequencer enables outside failsafe, external rails the device's own
    assign ch_en = {ext_enable_q, rail_on_in & {3{~failsafe_q}}, 1'b1};

    genvar g;
    generate
        for (g = 0; g < svs_pkg::NCH; g = g + 1) begin : g_ch
            svs_filter #(
                .DEG     (DEG),
                .STG     ((g == svs_pkg::CH_IFACE) ? IFACE_STG : RAIL_STG),
                .HAS_DUV ((g == svs_pkg::CH_RAIL1) || (g == svs_pkg::CH_RAIL2))
            ) u_filt (
                .clk     (clk),
                .nrst    (nrst),
                .en      (ch_en[g]),
                .ov      (ov_s[g]),
                .uv      (uv_s[g]),
                .duv     (duv_s[g]),
                .ov_evt  (ov_e[g]),
                .uv_evt  (uv_e[g]),
                .stg_evt (stg_e[g])
            );
        end
    endgenerate

    // ==========================================
    // reset output and hard reset
    logic drive_d;
    logic stg0_q;

    assign drive_d = ov_e[svs_pkg::CH_IFACE] | uv_e[svs_pkg::CH_IFACE] | stg_e[svs_pkg::CH_IFACE];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reset_output_o    <= 1'b0;
            reset_output_oe_n <= 1'b1;
        end else begin
            reset_output_o    <= 1'b0;
            reset_output_oe_n <= ~drive_d;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stg0_q       <= 1'b0;
            hard_reset_q <= 1'b0;
        end else begin
            stg0_q       <= stg_e[svs_pkg::CH_IFACE];
            hard_reset_q <= stg_e[svs_pkg::CH_IFACE] & ~stg0_q;
        end
    end

    // ==========================================
    // failsafe and external rail enables
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            failsafe_q <= 1'b0;
        end else if (|err_s) begin
            failsafe_q <= 1'b1;
        end
    end

    logic [1:0] ext_trip;
    logic [1:0] ext_tripped_q;

    assign ext_trip = ov_e[svs_pkg::CH_EXT1 +: svs_pkg::NEXT] | stg_e[svs_pkg::CH_EXT1 +: svs_pkg::NEXT];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_tripped_q <= 2'h0;
        end else begin
            ext_tripped_q <= (ext_tripped_q | ext_trip) & ext_on_req;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_enable_q <= 2'h0;
        end else begin
            ext_enable_q <= ext_on_req & ~ext_tripped_q & ~ext_trip
                            & {2{~failsafe_q & ~(|err_s)}};
        end
    end

    // ==========================================
    // sticky status, clear and enable
    logic [31:0] status_q;
    logic [31:0] enable_q;
    logic [31:0] set_v;
    logic [31:0] clr_v;

    always_comb begin
        set_v = 32'h0;
        set_v[svs_pkg::POS_UV  +: svs_pkg::NCH] = uv_e;
        set_v[svs_pkg::POS_UV + svs_pkg::CH_IFACE] = uv_e[svs_pkg::CH_IFACE] | stg_e[svs_pkg::CH_IFACE];
        set_v[svs_pkg::POS_OV  +: svs_pkg::NCH] = ov_e;
        set_v[svs_pkg::POS_STG +: svs_pkg::NCH] = stg_e;
        set_v[svs_pkg::POS_BATT] = batt_s;
        set_v[svs_pkg::POS_WARN +: 2] = warn_s;
        set_v[svs_pkg::POS_ERR  +: 2] = err_s;
        set_v[svs_pkg::POS_FAILSAFE] = failsafe_q;
    end

    assign clr_v = (wr && addr == svs_pkg::OFF_CLEAR) ? wdata : 32'h0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= svs_pkg::STATUS_RST;
        end else begin
            status_q <= (status_q & ~clr_v) | set_v;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            enable_q <= svs_pkg::ENABLE_RST;
        end else if (wr && addr == svs_pkg::OFF_ENABLE) begin
            enable_q <= wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & enable_q);
        end
    end

    // ==========================================
    // read port
    logic [31:0] live_v;
    logic [31:0] rd_v;

    always_comb begin
        live_v = 32'h0;
        live_v[svs_pkg::POS_UV  +: svs_pkg::NCH] = uv_e;
        live_v[svs_pkg::POS_OV  +: svs_pkg::NCH] = ov_e;
        live_v[svs_pkg::POS_STG +: svs_pkg::NCH] = stg_e;
        live_v[svs_pkg::POS_BATT] = batt_s;
        live_v[svs_pkg::POS_WARN +: 2] = warn_s;
        live_v[svs_pkg::POS_ERR  +: 2] = err_s;
        live_v[svs_pkg::POS_FAILSAFE] = failsafe_q;
        case (addr)
            svs_pkg::OFF_STATUS: rd_v = status_q;
            svs_pkg::OFF_ENABLE: rd_v = enable_q;
            svs_pkg::OFF_LIVE:   rd_v = live_v;
            default:             rd_v = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h0;
        end else if (rd) begin
            rdata_q <= rd_v;
        end else begin
            rdata_q <= 32'h0;
        end
    end

    // ==========================================
    // checks
    a_reset_drive: assert property (@(posedge clk) disable iff (!nrst)
        (ov_e[0] || uv_e[0]) |=> !reset_output_oe_n && !reset_output_o)
        else $error("reset output not driven low on interface supply fault");

    a_reset_release: assert property (@(posedge clk) disable iff (!nrst)
        !drive_d |=> reset_output_oe_n)
        else $error("reset output driven with no reset pending");

    a_iface_stg_flag: assert property (@(posedge clk) disable iff (!nrst)
        stg_e[0] |=> status_q[svs_pkg::POS_UV] && status_q[svs_pkg::POS_STG])
        else $error("interface short-to-ground not flagged");

    a_hard_reset: assert property (@(posedge clk) disable iff (!nrst)
        $rose(stg_e[0]) |=> hard_reset_q ##1 !hard_reset_q)
        else $error("hard reset pulse missing on interface short-to-ground");

    a_batt_flag: assert property (@(posedge clk) disable iff (!nrst)
        batt_s |=> status_q[svs_pkg::POS_BATT])
        else $error("battery low flag not set");

    a_rail_stg: assert property (@(posedge clk) disable iff (!nrst)
        (stg_e[1] || stg_e[2] || stg_e[3]) |=> |status_q[svs_pkg::POS_STG + 1 +: 3])
        else $error("rail short-to-ground not recorded");

    a_ext_trip: assert property (@(posedge clk) disable iff (!nrst)
        ext_trip[0] |=> !ext_enable_q[0] [*2])
        else $error("external rail left enabled after a trip");

    a_warn_irq: assert property (@(posedge clk) disable iff (!nrst)
        (warn_s[0] && enable_q[svs_pkg::POS_WARN] && !(wr && addr == svs_pkg::OFF_ENABLE)) |-> ##2 irq_q)
        else $error("reference warning did not raise the interrupt");

    a_fault_safe: assert property (@(posedge clk) disable iff (!nrst)
        (|err_s) |=> failsafe_q && ext_enable_q == 2'h0 && ch_en[3:1] == 3'h0)
        else $error("reference fault did not enter failsafe");

    a_ext_filter: assert property (@(posedge clk) disable iff (!nrst)
        !ch_en[svs_pkg::CH_EXT1] |=> !uv_e[svs_pkg::CH_EXT1])
        else $error("disabled external rail raised an event");
endmodule

/* File: dv/svs_mcu_model.sv */
`timescale 1ns/1ps
// ==========================================
// controller side: pulled-up reset pin, interrupt line, hard reset counter
module svs_mcu_model (
    // supervisor pins
    input  wire logic clk,
    input  wire logic reset_output_o,
    input  wire logic reset_output_oe_n,
    input  wire logic hard_reset_q,
    input  wire logic irq_q,
    // levels as the controller sees them
    output logic      pin_level,
    output logic      irq_seen,
    output int        hr_count
);
    // ==========================================
    // pull-up holds the pin high whenever the supervisor lets go
    assign pin_level = (reset_output_oe_n === 1'b0) ? reset_output_o : 1'b1;
    assign irq_seen  = irq_q;

    // ==========================================
    // count hard reset pulses away from the launching edge
    initial hr_count = 0;
    always @(negedge clk) begin
        if (hard_reset_q === 1'b1) begin
            hr_count = hr_count + 1;
        end
    end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
    // ==========================================
    // shortened counts and stimulus
    localparam int IS = 40;
    localparam int RS = 30;
    localparam int DG = 8;
    logic        clk            = 1'b0;
    logic        nrst           = 1'b0;
    logic        iface_ov_in    = 1'b0;
    logic        iface_uv_in    = 1'b0;
    logic [2:0]  rail_ov_in     = 3'h0;
    logic [2:0]  rail_uv_in     = 3'h0;
    logic [1:0]  rail_duv_in    = 2'h0;
    logic [1:0]  ext_ov_in      = 2'h0;
    logic [1:0]  ext_uv_in      = 2'h0;
    logic        battery_low_in = 1'b0;
    logic [1:0]  ref_warn_in    = 2'h0;
    logic [1:0]  ref_err_in     = 2'h0;
    logic [2:0]  rail_on_in     = 3'h0;
    logic [1:0]  ext_on_req     = 2'h0;
    logic [7:0]  addr           = 8'h00;
    logic [31:0] wdata          = 32'h0;
    logic        wr             = 1'b0;
    logic        rd             = 1'b0;
    logic        rd_d           = 1'b0;
    logic [31:0] rdata_q;
    logic        reset_output_o;
    logic        reset_output_oe_n;
    logic        hard_reset_q;
    logic        failsafe_q;
    logic [1:0]  ext_enable_q;
    logic        irq_q;
    logic        pin_level;
    logic        irq_seen;
    int          hr_count;
    int          n_errors       = 0;
    int          num_checks     = 0;
    int          k;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] e;
    logic [31:0] m;
    logic [31:0] en;

    always #5 clk = ~clk;

    svs_top #(.IFACE_STG(IS), .RAIL_STG(RS), .DEG(DG)) svs_top_i (
        .clk(clk), .nrst(nrst), .iface_ov_in(iface_ov_in), .iface_uv_in(iface_uv_in),
        .rail_ov_in(rail_ov_in), .rail_uv_in(rail_uv_in), .rail_duv_in(rail_duv_in),
        .ext_ov_in(ext_ov_in), .ext_uv_in(ext_uv_in), .battery_low_in(battery_low_in),
        .ref_warn_in(ref_warn_in), .ref_err_in(ref_err_in), .rail_on_in(rail_on_in),
        .ext_on_req(ext_on_req), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
        .reset_output_o(reset_output_o), .reset_output_oe_n(reset_output_oe_n),
        .hard_reset_q(hard_reset_q), .failsafe_q(failsafe_q), .ext_enable_q(ext_enable_q), .irq_q(irq_q)
    );

    svs_mcu_model svs_mcu_model_i (
        .clk(clk), .reset_output_o(reset_output_o), .reset_output_oe_n(reset_output_oe_n),
        .hard_reset_q(hard_reset_q), .irq_q(irq_q), .pin_level(pin_level), .irq_seen(irq_seen),
        .hr_count(hr_count)
    );

    // ==========================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] x, input logic [31:0] mk);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(x);
        msk_q.push_back(mk);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic clear_all();
        wait_cyc(10);
        wr_reg(svs_pkg::OFF_CLEAR, 32'hffff_ffff);
    endtask

    function automatic logic [31:0] bit_at(input int p);
        return 32'h1 << p;
    endfunction

    task automatic test_done();
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================
    // read data checker: oldest note against the answer cycle
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d === 1'b1) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk(rdata_q & m, e & m);
        end
    end

    // ==========================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end

    // ==========================================
    // main sequence
    initial begin
        void'($urandom(50986));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        wait_cyc(1);
        chk(32'(pin_level), 32'h1);
        rd_reg(svs_pkg::OFF_STATUS, svs_pkg::STATUS_RST, '1);
        rd_reg(svs_pkg::OFF_ENABLE, svs_pkg::ENABLE_RST, '1);
        rd_reg(8'h10, 32'h0, '1);
        rd_reg(svs_pkg::OFF_CLEAR, 32'h0, '1);
        // short glitches stay unseen
        @(posedge clk);
        rail_on_in <= 3'h7;
        iface_uv_in <= 1'b1;
        rail_ov_in <= 3'h7;
        repeat ($urandom_range(DG - 3, 1)) @(posedge clk);
        iface_uv_in <= 1'b0;
        rail_ov_in <= 3'h0;
        wait_cyc(20);
        chk(32'(pin_level), 32'h1);
        rd_reg(svs_pkg::OFF_STATUS, 32'h0, '1);
        // interface overvoltage pulls the pin low, release lets it rise
        @(posedge clk);
        iface_ov_in <= 1'b1;
        wait_cyc(25);
        chk(32'(pin_level), 32'h0);
        @(posedge clk);
        iface_ov_in <= 1'b0;
        wait_cyc(20);
        chk(32'(pin_level), 32'h1);
        rd_reg(svs_pkg::OFF_STATUS, bit_at(svs_pkg::POS_OV), '1);
        chk(32'(hr_count), 32'h0);
        clear_all();
        // interface short to ground
        @(posedge clk);
        iface_uv_in <= 1'b1;
        wait_cyc(IS + 20);
        chk(32'(pin_level), 32'h0);
        @(posedge clk);
        iface_uv_in <= 1'b0;
        wait_cyc(10);
        chk(32'(hr_count), 32'h1);
        rd_reg(svs_pkg::OFF_STATUS, bit_at(svs_pkg::POS_UV) | bit_at(svs_pkg::POS_STG), 32'h1001);
        clear_all();
        // rails off: no supervision
        @(posedge clk);
        rail_on_in <= 3'h0;
        rail_uv_in <= 3'h7;
        wait_cyc(RS + 20);
        @(posedge clk);
        rail_uv_in <= 3'h0;
        rail_on_in <= 3'h7;
        wait_cyc(10);
        rd_reg(svs_pkg::OFF_STATUS, 32'h0, '1);
        for (k = 0; k < 3; k++) begin
            rail_ov_in[k] <= 1'b1;
            wait_cyc(20);
            @(posedge clk);
            rail_ov_in[k] <= 1'b0;
            rail_uv_in[k] <= 1'b1;
            wait_cyc(RS + 20);
            @(posedge clk);
            rail_uv_in[k] <= 1'b0;
            wait_cyc(10);
            en = bit_at(svs_pkg::POS_OV + 1 + k) | bit_at(svs_pkg::POS_UV + 1 + k);
            rd_reg(svs_pkg::OFF_STATUS, en | bit_at(svs_pkg::POS_STG + 1 + k), '1);
            clear_all();
            if (k < 2) begin
                rail_duv_in[k] <= 1'b1;
                wait_cyc(20);
                @(posedge clk);
                rail_duv_in[k] <= 1'b0;
                wait_cyc(10);
                rd_reg(svs_pkg::OFF_STATUS, bit_at(svs_pkg::POS_STG + 1 + k), '1);
                clear_all();
            end
        end
        // external rails: undervoltage keeps, short and overvoltage trip
        for (k = 0; k < 2; k++) begin
            ext_on_req[k] <= 1'b1;
            wait_cyc(3);
            @(posedge clk);
            ext_uv_in[k] <= 1'b1;
            wait_cyc(20);
            chk(32'(ext_enable_q[k]), 32'h1);
            wait_cyc(RS + 10);
            chk(32'(ext_enable_q[k]), 32'h0);
            @(posedge clk);
            ext_uv_in[k] <= 1'b0;
            ext_on_req[k] <= 1'b0;
            en = bit_at(svs_pkg::POS_UV + 4 + k) | bit_at(svs_pkg::POS_STG + 4 + k);
            rd_reg(svs_pkg::OFF_STATUS, en, '1);
            clear_all();
            ext_on_req[k] <= 1'b1;
            wait_cyc(3);
            @(posedge clk);
            ext_ov_in[k] <= 1'b1;
            wait_cyc(20);
            chk(32'(ext_enable_q[k]), 32'h0);
            @(posedge clk);
            ext_ov_in[k] <= 1'b0;
            ext_on_req[k] <= 1'b0;
            rd_reg(svs_pkg::OFF_STATUS, bit_at(svs_pkg::POS_OV + 4 + k), '1);
            clear_all();
        end
        // battery low
        battery_low_in <= 1'b1;
        wait_cyc(20);
        @(posedge clk);
        battery_low_in <= 1'b0;
        rd_reg(svs_pkg::OFF_STATUS, bit_at(svs_pkg::POS_BATT), '1);
        clear_all();
        // reference warning: masked, enabled, cleared
        k = $urandom_range(1);
        ref_warn_in[k] <= 1'b1;
        wait_cyc(20);
        @(posedge clk);
        ref_warn_in[k] <= 1'b0;
        wait_cyc(10);
        chk(32'(irq_seen), 32'h0);
        en = ($urandom() & 32'h00ff_ffff) | bit_at(svs_pkg::POS_WARN + k);
        wr_reg(svs_pkg::OFF_ENABLE, en);
        rd_reg(svs_pkg::OFF_ENABLE, en, 32'h00ff_ffff);
        rd_reg(svs_pkg::OFF_STATUS, bit_at(svs_pkg::POS_WARN + k), '1);
        wait_cyc(3);
        chk(32'(irq_seen), 32'h1);
        wr_reg(svs_pkg::OFF_CLEAR, bit_at(svs_pkg::POS_WARN + k));
        wait_cyc(3);
        chk(32'(irq_seen), 32'h0);
        // reference fault: failsafe, rails shut
        @(posedge clk);
        ext_on_req <= 2'h3;
        wait_cyc(3);
        chk(32'(ext_enable_q), 32'h3);
        k = $urandom_range(1);
        @(posedge clk);
        ref_err_in[k] <= 1'b1;
        wait_cyc(20);
        chk(32'(failsafe_q), 32'h1);
        chk(32'(ext_enable_q), 32'h0);
        en = bit_at(svs_pkg::POS_ERR + k) | bit_at(svs_pkg::POS_FAILSAFE);
        rd_reg(svs_pkg::OFF_STATUS, en, en);
        rd_reg(svs_pkg::OFF_LIVE, en, '1);
        wait_cyc(3);
        test_done();
    end
endmodule

/* File: shared/svs_pkg.sv */
// ==========================================
// supervisor constants
package svs_pkg;
    // ==========================================
    // clock and timing
    localparam int CLK_MHZ        = 100;
    localparam int DEG_TIME_US    = 8;
    localparam int IFACE_STG_US   = 4000;
    localparam int RAIL_STG_US    = 3000;
    localparam int DEG_CYC        = DEG_TIME_US * CLK_MHZ;
    localparam int IFACE_STG_CYC  = IFACE_STG_US * CLK_MHZ;
    localparam int RAIL_STG_CYC   = RAIL_STG_US * CLK_MHZ;

    // ==========================================
    // channels
    localparam int NCH            = 6;
    localparam int CH_IFACE       = 0;
    localparam int CH_RAIL1       = 1;
    localparam int CH_RAIL2       = 2;
    localparam int CH_RAIL3       = 3;
    localparam int CH_EXT1        = 4;
    localparam int NEXT           = 2;

    // ==========================================
    // register port
    localparam int AW             = 8;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CLEAR  = 8'h04;
    localparam logic [7:0] OFF_ENABLE = 8'h08;
    localparam logic [7:0] OFF_LIVE   = 8'h0c;

    // ==========================================
    // status layout
    localparam int POS_UV         = 0;
    localparam int POS_OV         = 6;
    localparam int POS_STG        = 12;
    localparam int POS_BATT       = 18;
    localparam int POS_WARN       = 19;
    localparam int POS_ERR        = 21;
    localparam int POS_FAILSAFE   = 23;
    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
endpackage
